/* File: hdl/mcsr_top.sv */
// motor-control status readback: telemetry words and state behind an AHB-Lite slave
// assumes: single word transfers, one slave on the bus, samples synchronous to clock
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "mcsr_consts.svh"

module mcsr_top (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire mcsr_pkg::mcsr_sample_t state_sample,
  input  wire mcsr_pkg::mcsr_sample_t speed_sample,
  input  wire mcsr_pkg::mcsr_sample_t bus_current_sample,
  input  wire mcsr_pkg::mcsr_sample_t phase_a_sample,
  input  wire mcsr_pkg::mcsr_sample_t phase_b_sample,
  output logic                      irq
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ****************************************
  // telemetry holding registers
  // ****************************************
  logic [15:0] control_state_word;
  logic [31:0] pulse_speed_estimate;
  logic [31:0] supply_current_estimate;
  logic [31:0] first_phase_current;
  logic [31:0] second_phase_current;
  logic        state_legal;
  logic        state_load;

  // codes above the last state are dropped, the word keeps its old value
  assign state_legal = (state_sample.value[15:0] <= `MCSR_STATE_MAX);
  assign state_load  = state_sample.valid && state_legal;

  mcsr_capture #(.W(`MCSR_STATE_W)) u_state (
    .clock (clock),
    .rst_n (rst_sync_n),
    .load  (state_load),
    .din   (state_sample.value[15:0]),
    .q     (control_state_word)
  );

  mcsr_capture #(.W(32)) u_speed (
    .clock (clock),
    .rst_n (rst_sync_n),
    .load  (speed_sample.valid),
    .din   (speed_sample.value),
    .q     (pulse_speed_estimate)
  );

  mcsr_capture #(.W(32)) u_bus_current (
    .clock (clock),
    .rst_n (rst_sync_n),
    .load  (bus_current_sample.valid),
    .din   (bus_current_sample.value),
    .q     (supply_current_estimate)
  );

  mcsr_capture #(.W(32)) u_phase_a (
    .clock (clock),
    .rst_n (rst_sync_n),
    .load  (phase_a_sample.valid),
    .din   (phase_a_sample.value),
    .q     (first_phase_current)
  );

  mcsr_capture #(.W(32)) u_phase_b (
    .clock (clock),
    .rst_n (rst_sync_n),
    .load  (phase_b_sample.valid),
    .din   (phase_b_sample.value),
    .q     (second_phase_current)
  );

  // ****************************************
  // bus address phase decode
  // ****************************************
  logic                   xfer;
  logic                   word_ok;
  logic [`MCSR_IDX_W-1:0] idx;

  assign xfer    = hsel && htrans[1] && hready;
  assign word_ok = (haddr[31:`MCSR_IDX_W+2] == '0) && (haddr[1:0] == 2'b00);
  assign idx     = haddr[`MCSR_IDX_W+1:2];

  // ****************************************
  // interrupt events
  // ****************************************
  logic [`MCSR_IRQ_W-1:0] irq_status;
  logic [`MCSR_IRQ_W-1:0] irq_mask;
  logic [`MCSR_IRQ_W-1:0] ev;

  always_comb begin
    ev = '0;
    if (state_load && (state_sample.value[15:0] != control_state_word)) begin
      ev[`MCSR_IRQ_CHANGE] = 1'b1;
      if (state_sample.value[15:0] == `MCSR_STATE_FAULT ||
          state_sample.value[15:0] == `MCSR_STATE_PM_FAULT) begin
        ev[`MCSR_IRQ_FAULT] = 1'b1;
      end
      if (state_sample.value[15:0] == `MCSR_STATE_PM_DONE) begin
        ev[`MCSR_IRQ_DONE] = 1'b1;
      end
    end
  end

  // ****************************************
  // bus state
  // ****************************************
  logic                   wr_pend;
  logic [`MCSR_IDX_W-1:0] wr_idx;
  logic                   next_wr_pend;
  logic [`MCSR_IDX_W-1:0] next_wr_idx;
  logic [31:0]            next_hrdata;
  logic [`MCSR_IRQ_W-1:0] next_irq_status;
  logic [`MCSR_IRQ_W-1:0] next_irq_mask;
  logic                   next_irq;

  always_comb begin
    next_wr_pend    = xfer && hwrite && word_ok;
    next_wr_idx     = idx;
    next_hrdata     = hrdata;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    if (xfer && !hwrite) begin
      // reads only select, nothing is cleared by them
      next_hrdata = `MCSR_RESET_WORD;
      if (word_ok) begin
        unique case (idx)
          `MCSR_IDX_STATE:       next_hrdata = {16'h0000, control_state_word};
          `MCSR_IDX_SPEED:       next_hrdata = pulse_speed_estimate;
          `MCSR_IDX_BUS_CURRENT: next_hrdata = supply_current_estimate;
          `MCSR_IDX_PHASE_A:     next_hrdata = first_phase_current;
          `MCSR_IDX_PHASE_B:     next_hrdata = second_phase_current;
          `MCSR_IDX_IRQ_STATUS:  next_hrdata = {29'h0, irq_status};
          `MCSR_IDX_IRQ_MASK:    next_hrdata = {29'h0, irq_mask};
          default:               next_hrdata = `MCSR_RESET_WORD;
        endcase
      end
    end
    // data phase of a write: only interrupt words accept data
    if (wr_pend && wr_idx == `MCSR_IDX_IRQ_MASK) begin
      next_irq_mask = hwdata[`MCSR_IRQ_W-1:0];
    end
    if (wr_pend && wr_idx == `MCSR_IDX_IRQ_STATUS) begin
      next_irq_status = irq_status & ~hwdata[`MCSR_IRQ_W-1:0];
    end
    // set wins over clear
    next_irq_status = next_irq_status | ev;
    next_irq        = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend    <= 1'b0;
      wr_idx     <= '0;
      hrdata     <= `MCSR_RESET_WORD;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      irq_status <= `MCSR_RESET_IRQ;
      irq_mask   <= `MCSR_RESET_IRQ;
      irq        <= 1'b0;
    end else begin
      wr_pend    <= next_wr_pend;
      wr_idx     <= next_wr_idx;
      hrdata     <= next_hrdata;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq        <= next_irq;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  logic rd_state;
  logic rd_speed;
  logic rd_bus;
  logic rd_pha;
  logic rd_phb;

  assign rd_state = xfer && !hwrite && word_ok && idx == `MCSR_IDX_STATE;
  assign rd_speed = xfer && !hwrite && word_ok && idx == `MCSR_IDX_SPEED;
  assign rd_bus   = xfer && !hwrite && word_ok && idx == `MCSR_IDX_BUS_CURRENT;
  assign rd_pha   = xfer && !hwrite && word_ok && idx == `MCSR_IDX_PHASE_A;
  assign rd_phb   = xfer && !hwrite && word_ok && idx == `MCSR_IDX_PHASE_B;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync_n);

  a_state_read_upper: assert property (
    rd_state |=> (hrdata[31:16] == 16'h0000) && (hrdata[15:0] == $past(control_state_word)))
    else $error("state word read wrong");

  a_state_code_legal: assert property (
    control_state_word <= `MCSR_STATE_MAX)
    else $error("state code out of range");

  a_state_code_load: assert property (
    state_sample.valid && !state_legal |=> $stable(control_state_word))
    else $error("illegal state code stored");

  a_speed_read_val: assert property (
    rd_speed |=> hrdata == $past(pulse_speed_estimate))
    else $error("speed read wrong");

  a_bus_read_val: assert property (
    rd_bus |=> hrdata == $past(supply_current_estimate))
    else $error("supply current read wrong");

  a_phase_a_read: assert property (
    phase_a_sample.valid ##1 !phase_a_sample.valid ##1 rd_pha
      |=> hrdata == $past(phase_a_sample.value, 3))
    else $error("first phase read wrong");

  a_phase_b_read: assert property (
    rd_phb |=> hrdata == $past(second_phase_current))
    else $error("second phase read wrong");

  a_write_ignored: assert property (
    wr_pend && !speed_sample.valid && !phase_a_sample.valid |=>
      $stable(pulse_speed_estimate) && $stable(first_phase_current))
    else $error("write changed status word");

  a_irq_level_match: assert property (
    ev != '0 && (ev & irq_mask) != '0 && !(wr_pend && wr_idx == `MCSR_IDX_IRQ_MASK)
      |=> irq && hreadyout && !hresp)
    else $error("interrupt missed");

  c_read_state: cover property (rd_state ##1 hrdata[15:0] != 16'h0000);
  c_irq_rise:   cover property (!irq ##1 irq);
  c_fault_seen: cover property (ev[`MCSR_IRQ_FAULT] ##[1:4] rd_state);

endmodule // mcsr_top

/* File: shared/mcsr_consts.svh */
// register indices, field positions, reset values and interrupt layout of the status readback block
// assumes: byte address of a register is four times its index
`ifndef MCSR_CONSTS_SVH
`define MCSR_CONSTS_SVH

`define MCSR_IDX_W            12
`define MCSR_IDX_STATE        12'h210
`define MCSR_IDX_SPEED        12'h216
`define MCSR_IDX_BUS_CURRENT  12'h410
`define MCSR_IDX_PHASE_A      12'h43E
`define MCSR_IDX_PHASE_B      12'h440
`define MCSR_IDX_IRQ_STATUS   12'h7F0
`define MCSR_IDX_IRQ_MASK     12'h7F1

`define MCSR_STATE_LSB        0
`define MCSR_STATE_W          16
`define MCSR_STATE_MAX        16'h0018
`define MCSR_STATE_FAULT      16'h000E
`define MCSR_STATE_PM_DONE    16'h0017
`define MCSR_STATE_PM_FAULT   16'h0018

`define MCSR_FRAC_BITS        27
`define MCSR_CURRENT_FULL_MA  1250

`define MCSR_IRQ_W            3
`define MCSR_IRQ_CHANGE       0
`define MCSR_IRQ_FAULT        1
`define MCSR_IRQ_DONE         2

`define MCSR_RESET_WORD       32'h0000_0000
`define MCSR_RESET_STATE      16'h0000
`define MCSR_RESET_IRQ        3'h0

`endif

/* File: shared/mcsr_pkg.sv */
// types of the motor-control status readback block
// assumes: constants come from mcsr_consts.svh
package mcsr_pkg;

  // control state codes
  typedef enum logic [15:0] {
    MCSR_IDLE             = 16'h0000,
    MCSR_ISD              = 16'h0001,
    MCSR_TRISTATE         = 16'h0002,
    MCSR_BRAKE_ON_START   = 16'h0003,
    MCSR_IPD              = 16'h0004,
    MCSR_SLOW_FIRST_CYCLE = 16'h0005,
    MCSR_ALIGN            = 16'h0006,
    MCSR_OPEN_LOOP        = 16'h0007,
    MCSR_CL_UNALIGNED     = 16'h0008,
    MCSR_CL_ALIGNED       = 16'h0009,
    MCSR_CL_ACTIVE_BRAKE  = 16'h000A,
    MCSR_SOFT_STOP        = 16'h000B,
    MCSR_RECIRC_STOP      = 16'h000C,
    MCSR_BRAKE_ON_STOP    = 16'h000D,
    MCSR_FAULT            = 16'h000E,
    MCSR_PM_STOP_CHECK    = 16'h000F,
    MCSR_PM_STOP_WAIT     = 16'h0010,
    MCSR_PM_BRAKE         = 16'h0011,
    MCSR_PM_PARAM_INIT    = 16'h0012,
    MCSR_PM_RL_MEASURE    = 16'h0013,
    MCSR_PM_KE_MEASURE    = 16'h0014,
    MCSR_PM_STALL_MEASURE = 16'h0015,
    MCSR_PM_TORQUE_MODE   = 16'h0016,
    MCSR_PM_DONE          = 16'h0017,
    MCSR_PM_FAULT         = 16'h0018
  } mcsr_state_t;

  // one telemetry word from the control algorithm
  typedef struct packed {
    logic        valid;
    logic [31:0] value;
  } mcsr_sample_t;

endpackage

/* File: hdl/mcsr_capture.sv */
// one telemetry holding register, loaded whenever its load input is high
// assumes: load is synchronous to clock; reset already synchronised
`timescale 1ns/1ps
`include "mcsr_consts.svh"

module mcsr_capture #(
  parameter int W = 32
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] q
);

  logic [W-1:0] next_q;

  always_comb begin
    next_q = q;
    if (load) begin
      next_q = din;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule // mcsr_capture

/* File: verification/motor_control_status_readback_tb.sv */
// self-checking bench for the motor-control status readback block
// assumes: mcsr_top with its package and constants header on the include path
`timescale 1ns/1ps
`include "mcsr_consts.svh"

module motor_control_status_readback_tb;
  logic                   clock;
  logic                   rst_n;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [2:0]             hsize;
  logic [31:0]            hwdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [31:0]            hrdata;
  logic                   irq;
  mcsr_pkg::mcsr_sample_t smp [5];
  logic [31:0]            mreg [7];
  logic [31:0]            adr [7];
  logic [31:0]            rv;
  logic [31:0]            v;
  int                     n_fail;
  int                     checked;
  int                     k;
  logic [31:0]            seed;

  mcsr_top u_dut (
    .clock              (clock),
    .rst_n              (rst_n),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (hsize),
    .hwdata             (hwdata),
    .hready             (hreadyout),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .hrdata             (hrdata),
    .state_sample       (smp[0]),
    .speed_sample       (smp[1]),
    .bus_current_sample (smp[2]),
    .phase_a_sample     (smp[3]),
    .phase_b_sample     (smp[4]),
    .irq                (irq)
  );

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task print_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single word transfer, address phase then data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 32);
    rv = hrdata;
    if (n >= 32) n_fail++;
  endtask

  task rdchk(input int r);
    xfer(1'b0, adr[r], 32'h0);
    chk($sformatf("reg%0d", r), mreg[r], rv);
    chk("ready_resp_irq", {29'h0, 1'b1, 1'b0, |(mreg[5] & mreg[6])},
        {29'h0, hreadyout, hresp, irq});
  endtask

  // model: status words ignore writes, status is write-one-to-clear
  task wr(input int r, input logic [31:0] d);
    xfer(1'b1, adr[r], d);
    if (r == 5) mreg[5] = mreg[5] & ~d & 32'h7;
    if (r == 6) mreg[6] = d & 32'h7;
  endtask

  // one-cycle sample strobe; state codes above the last code are dropped
  task put(input int r, input logic [31:0] d);
    @(posedge clock);
    smp[r] <= '{valid: 1'b1, value: d};
    @(posedge clock);
    smp[r].valid <= 1'b0;
    if (r != 0) begin
      mreg[r] = d;
    end else if (d[15:0] <= `MCSR_STATE_MAX) begin
      if (d[15:0] != mreg[0][15:0]) begin
        mreg[5][`MCSR_IRQ_CHANGE] = 1'b1;
        if (d[15:0] == `MCSR_STATE_FAULT || d[15:0] == `MCSR_STATE_PM_FAULT)
          mreg[5][`MCSR_IRQ_FAULT] = 1'b1;
        if (d[15:0] == `MCSR_STATE_PM_DONE) mreg[5][`MCSR_IRQ_DONE] = 1'b1;
      end
      mreg[0] = {16'h0, d[15:0]};
    end
  endtask

  task do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (mreg[i]) mreg[i] = 32'h0;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    seed = 32'd97;
    n_fail = 0;
    checked = 0;
    foreach (smp[i]) smp[i] = '0;
    adr[0] = 32'(4 * `MCSR_IDX_STATE);
    adr[1] = 32'(4 * `MCSR_IDX_SPEED);
    adr[2] = 32'(4 * `MCSR_IDX_BUS_CURRENT);
    adr[3] = 32'(4 * `MCSR_IDX_PHASE_A);
    adr[4] = 32'(4 * `MCSR_IDX_PHASE_B);
    adr[5] = 32'(4 * `MCSR_IDX_IRQ_STATUS);
    adr[6] = 32'(4 * `MCSR_IDX_IRQ_MASK);
    do_reset();
    for (int r = 0; r < 7; r++) rdchk(r);
    xfer(1'b0, 32'h0000_0004, 32'h0);
    chk("unmapped", 32'h0, rv);
    wr(6, 32'hFFFF_FFFF);
    for (int c = 0; c <= 26; c++) begin
      put(0, 32'hA5A5_0000 | 32'(c));
      rdchk(0);
      rdchk(5);
    end
    put(3, xs());
    rdchk(3);
    wr(5, 32'h3);
    rdchk(5);
    wr(6, 32'h3);
    rdchk(6);
    wr(5, 32'h7);
    rdchk(5);
    for (int i = 0; i < 60; i++) begin
      k = int'(xs() % 5);
      v = xs();
      if (k == 0) v = (v & 32'hFFFF_0000) | (xs() % 26);
      put(k, v);
      wr(k, xs());
      rdchk(k);
      if (i % 8 == 7) begin
        wr(6, xs());
        wr(5, xs());
        rdchk(5);
      end
    end
    xfer(1'b0, adr[1] | 32'h0000_0002, 32'h0);
    chk("misaligned", 32'h0, rv);
    xfer(1'b0, adr[1] | 32'h0001_0000, 32'h0);
    chk("out_of_range", 32'h0, rv);
    for (int r = 0; r < 5; r++) put(r, 32'h0000_0011 + 32'(r));
    do_reset();
    for (int r = 0; r < 7; r++) rdchk(r);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    print_verdict();
  end
endmodule // motor_control_status_readback_tb
